// >>> sockext_pkg.sv
// shared constants for the socket extension register bank
package sockext_pkg;
  localparam logic [7:0] IDX_POWER_CTRL = 8'h02;
  localparam logic [7:0] IDX_SIGNATURE = 8'h1f;
  localparam logic [7:0] IDX_DRIVE_CTRL = 8'h26;
  localparam logic [7:0] IDX_EXT_INDEX = 8'h2e;
  localparam logic [7:0] IDX_EXT_DATA = 8'h2f;
  localparam logic [7:0] EXT_SCRATCH = 8'h00;
  localparam logic [7:0] EXT_MASK0 = 8'h01;
  localparam logic [7:0] EXT_MASK1 = 8'h02;
  localparam logic [7:0] EXT_CTRL1 = 8'h03;
  localparam logic [7:0] EXT_ACK_DELAY = 8'h04;
  localparam logic [7:0] EXT_RSVD_LO = 8'h05;
  localparam logic [7:0] EXT_RSVD_HI = 8'h09;
  localparam logic [7:0] EXT_OUT_DATA = 8'h0a;
  localparam logic [7:0] EXT_CTRL2 = 8'h0b;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam int DRV_DISK_MODE_BIT = 0;
  localparam int DRV_LAMP_INPUT_BIT = 1;
  localparam int DRV_ADDR_LSB = 3;
  localparam int DRV_ADDR_MSB = 7;
  localparam int DRV_ADDR_W = 5;
  localparam int PWR_SUPPLY_BIT = 4;
  localparam int CTL_POWER_LOCK_BIT = 0;
  localparam int CTL_AUTO_CLR_DIS_BIT = 1;
  localparam int CTL_ACT_LAMP_BIT = 2;
  localparam int CTL_PULLUP_OFF_BIT = 5;
  localparam int CTL_DMA_LSB = 6;
  localparam int CTL_DMA_MSB = 7;
  localparam logic [1:0] DMA_OFF = 2'h0;
  localparam logic [1:0] DMA_INPACK = 2'h1;
  localparam logic [1:0] DMA_WP = 2'h2;
  localparam logic [1:0] DMA_SPKR = 2'h3;
  localparam int SIG_ID_LSB = 6;
  localparam int SIG_ID_MSB = 7;
  localparam int SIG_DUAL_BIT = 5;
  localparam int SIG_REV_LSB = 1;
  localparam int SIG_REV_MSB = 4;
  localparam int PIN_PRESENT = 0;
  localparam int PIN_BVD2 = 1;
  localparam int PIN_INPACK = 2;
  localparam int PIN_WP = 3;
  localparam int PIN_COUNT = 4;
endpackage

// >>> socket_extension_regs.sv
// socket extension register bank: signature, drive control, indirect registers
`timescale 1ns/1ps
// Overview of operation
// [R1] Signature field gives first pattern after reset or write, then alternates per read.
// [R2] Drive control bit 0 switches the socket to disk drive interface.
// [R3] Speaker-as-lamp plus lamp drive enable routes card speaker onto IRQ12.
// [R4] In I/O or disk mode that bit makes the speaker pin an active-low lamp input.
// [R5] Software keeps speaker-as-lamp clear in memory card mode.
// [R6] In disk mode drive control bits 3..7 drive address lines A21..A25.
// [R7] Outside disk mode bits 3..7 are plain storage only.
// [R8] Index 2Eh selects the extended register reached at 2Fh.
// [R9] Extended index decodes scratch, masks, controls, delay, reserved, external data.
// [R10] Data port reads and writes the extended register currently selected.
// [R11] Mask 0 bits stop driving data bits for accesses in I/O map 0.
// [R12] Mask value zero, the reset value, drives all data bits.
// [R13] Any mask bit set forces that map's host accesses to 8-bit.
// [R14] Mask 1 works like mask 0 for I/O map 1.
// [R15] Power lock set makes supply enable ignore software writes.
// [R16] Card removal clears supply enable unless auto clear is disabled.
// [R17] Lamp drive enable makes IRQ12 open-drain, driven while speaker on and bit set.
// [R18] Activity lamp output is low while card cycles run, when enabled.
// [R19] Pull-up control bit turns off card-detect and strobe pull-ups.
// [R20] Nonzero DMA field enables DMA and picks the card request pin.
// [R21] Scratchpad bit stores and reads back with no side effect.
// [R22] Reserved extended indices ignore writes and read as zero.
// [R23] Per-socket registers are separate copies, all reset to zero.
module socket_extension_regs
  import sockext_pkg::*;
#(
  parameter int NUM_SOCKETS = 2,
  parameter logic [1:0] SIG_FIRST = 2'h2, // arbitrary value
  parameter logic [1:0] SIG_SECOND = 2'h1, // arbitrary value
  parameter logic [3:0] SIG_REVISION = 4'h5, // arbitrary value
  parameter logic SIG_BIT0 = 1'b0 // arbitrary value
) (
  input wire logic clock_i, // internal clock
  input wire logic rstn_i, // chip reset, active low
  input wire logic sock_i, // socket selected by the access
  input wire logic [7:0] index_i, // register index
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [7:0] wdata_i, // write data
  output logic [7:0] rdata_o, // read data
  output logic rvalid_o, // read data valid
  input wire logic lamp_drive_enable_i, // chip-level lamp drive enable
  input wire logic [NUM_SOCKETS-1:0] io_card_mode_i, // socket in I/O card mode
  input wire logic [NUM_SOCKETS-1:0] card_cycle_i, // card cycle in progress
  input wire logic [NUM_SOCKETS-1:0] io_map0_hit_i, // host access inside I/O map 0
  input wire logic [NUM_SOCKETS-1:0] io_map1_hit_i, // host access inside I/O map 1
  input wire logic [NUM_SOCKETS-1:0] card_present_i, // card detected, pin
  input wire logic [NUM_SOCKETS-1:0] battery_speaker_lamp_pin_i, // active-low pin
  input wire logic [NUM_SOCKETS-1:0] inpack_n_i, // input acknowledge pin
  input wire logic [NUM_SOCKETS-1:0] wp_iois16_n_i, // write protect pin
  output logic [NUM_SOCKETS-1:0] disk_interface_mode_o, // socket in disk mode
  output logic [NUM_SOCKETS-1:0][DRV_ADDR_W-1:0] drive_addr_o, // A21..A25
  output logic [NUM_SOCKETS-1:0] disk_lamp_o, // disk activity seen on lamp input
  output logic irq12_o, // IRQ12 open-drain level
  output logic irq12_oe_n_o, // IRQ12 enable, low drives
  output logic activity_lamp_out_n_o, // activity lamp, active low
  output logic [NUM_SOCKETS-1:0][7:0] data_drive_en_o, // per data bit drive enable
  output logic [NUM_SOCKETS-1:0] force_8bit_o, // force 8-bit host access
  output logic [NUM_SOCKETS-1:0] pullup_off_o, // pull-ups and inputs off
  output logic [NUM_SOCKETS-1:0] dma_mode_o, // socket in DMA mode
  output logic [NUM_SOCKETS-1:0] card_transfer_request_o, // card DMA request
  output logic [NUM_SOCKETS-1:0] card_supply_en_o // card supply enable
);
  logic [7:0] drive_q [NUM_SOCKETS];
  logic [7:0] ext_index_q [NUM_SOCKETS];
  logic [7:0] scratch_q [NUM_SOCKETS];
  logic [7:0] mask0_q [NUM_SOCKETS];
  logic [7:0] mask1_q [NUM_SOCKETS];
  logic [7:0] ctrl1_q [NUM_SOCKETS];
  logic [7:0] ackdly_q [NUM_SOCKETS];
  logic [7:0] outdata_q [NUM_SOCKETS];
  logic [7:0] ctrl2_q [NUM_SOCKETS];
  logic [7:0] power_q [NUM_SOCKETS];
  logic [PIN_COUNT-1:0] sync1_q [NUM_SOCKETS];
  logic [PIN_COUNT-1:0] sync2_q [NUM_SOCKETS];
  logic [NUM_SOCKETS-1:0] present_prev_q;
  logic [NUM_SOCKETS-1:0] removal;
  logic [NUM_SOCKETS-1:0] speaker_lamp;
  logic [NUM_SOCKETS-1:0] activity;
  logic sig_second_q;
  logic [7:0] rd_data_d;

  // pins pass two flip-flops before any logic looks at them
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        sync1_q[s] <= '0;
        sync2_q[s] <= '0;
      end
      present_prev_q <= '0;
    end else begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        sync1_q[s] <= {wp_iois16_n_i[s], inpack_n_i[s], battery_speaker_lamp_pin_i[s],
                       card_present_i[s]};
        sync2_q[s] <= sync1_q[s];
        present_prev_q[s] <= sync2_q[s][PIN_PRESENT];
      end
    end
  end

  always_comb begin
    for (int s = 0; s < NUM_SOCKETS; s++) begin
      removal[s] = present_prev_q[s] & ~sync2_q[s][PIN_PRESENT];
      speaker_lamp[s] = ~sync2_q[s][PIN_BVD2] & drive_q[s][DRV_LAMP_INPUT_BIT];
      activity[s] = card_cycle_i[s] & ctrl1_q[s][CTL_ACT_LAMP_BIT];
    end
  end

  // direct and indirect register writes, one copy per socket
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        drive_q[s] <= REG_RESET; // R23
        ext_index_q[s] <= REG_RESET;
        scratch_q[s] <= REG_RESET;
        mask0_q[s] <= MASK_NONE; // R12
        mask1_q[s] <= MASK_NONE;
        ctrl1_q[s] <= REG_RESET;
        ackdly_q[s] <= REG_RESET;
        outdata_q[s] <= REG_RESET;
        ctrl2_q[s] <= REG_RESET;
      end
    end else begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        if (wr_i && (int'(sock_i) == s)) begin
          if (index_i == IDX_DRIVE_CTRL) begin
            drive_q[s] <= wdata_i; // R6 R7
          end else if (index_i == IDX_EXT_INDEX) begin
            ext_index_q[s] <= wdata_i; // R8
          end else if (index_i == IDX_EXT_DATA) begin
            if (ext_index_q[s] == EXT_SCRATCH) begin // R9 R10
              scratch_q[s] <= wdata_i;
            end else if (ext_index_q[s] == EXT_MASK0) begin
              mask0_q[s] <= wdata_i;
            end else if (ext_index_q[s] == EXT_MASK1) begin
              mask1_q[s] <= wdata_i;
            end else if (ext_index_q[s] == EXT_CTRL1) begin
              ctrl1_q[s] <= wdata_i;
            end else if (ext_index_q[s] == EXT_ACK_DELAY) begin
              ackdly_q[s] <= wdata_i;
            end else if (ext_index_q[s] == EXT_OUT_DATA) begin
              outdata_q[s] <= wdata_i;
            end else if (ext_index_q[s] == EXT_CTRL2) begin
              ctrl2_q[s] <= wdata_i;
            end
            // reserved indices fall through and store nothing R22
          end
        end
      end
    end
  end

  // supply enable: lock blocks writes, removal clears and beats a write
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        power_q[s] <= REG_RESET;
      end
    end else begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        if (wr_i && (int'(sock_i) == s) && (index_i == IDX_POWER_CTRL)) begin
          power_q[s] <= wdata_i;
          if (ctrl1_q[s][CTL_POWER_LOCK_BIT]) begin
            power_q[s][PWR_SUPPLY_BIT] <= power_q[s][PWR_SUPPLY_BIT]; // R15
          end
        end
        if (removal[s] && !ctrl1_q[s][CTL_AUTO_CLR_DIS_BIT]) begin
          power_q[s][PWR_SUPPLY_BIT] <= 1'b0; // R16
        end
      end
    end
  end

  // signature toggles on each read, a write restarts the sequence
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sig_second_q <= 1'b0;
    end else if (wr_i && (index_i == IDX_SIGNATURE)) begin
      sig_second_q <= 1'b0; // R1
    end else if (rd_i && (index_i == IDX_SIGNATURE)) begin
      sig_second_q <= ~sig_second_q; // R1
    end
  end

  always_comb begin
    rd_data_d = REG_RESET;
    for (int s = 0; s < NUM_SOCKETS; s++) begin
      if (int'(sock_i) == s) begin
        if (index_i == IDX_SIGNATURE) begin
          rd_data_d[SIG_ID_MSB:SIG_ID_LSB] = sig_second_q ? SIG_SECOND : SIG_FIRST; // R1
          rd_data_d[SIG_DUAL_BIT] = (NUM_SOCKETS > 1);
          rd_data_d[SIG_REV_MSB:SIG_REV_LSB] = SIG_REVISION;
          rd_data_d[0] = SIG_BIT0;
        end else if (index_i == IDX_POWER_CTRL) begin
          rd_data_d = power_q[s];
        end else if (index_i == IDX_DRIVE_CTRL) begin
          rd_data_d = drive_q[s];
        end else if (index_i == IDX_EXT_INDEX) begin
          rd_data_d = ext_index_q[s];
        end else if (index_i == IDX_EXT_DATA) begin
          if (ext_index_q[s] == EXT_SCRATCH) begin // R10
            rd_data_d = scratch_q[s];
          end else if (ext_index_q[s] == EXT_MASK0) begin
            rd_data_d = mask0_q[s];
          end else if (ext_index_q[s] == EXT_MASK1) begin
            rd_data_d = mask1_q[s];
          end else if (ext_index_q[s] == EXT_CTRL1) begin
            rd_data_d = ctrl1_q[s];
          end else if (ext_index_q[s] == EXT_ACK_DELAY) begin
            rd_data_d = ackdly_q[s];
          end else if (ext_index_q[s] == EXT_OUT_DATA) begin
            rd_data_d = outdata_q[s];
          end else if (ext_index_q[s] == EXT_CTRL2) begin
            rd_data_d = ctrl2_q[s];
          end
          // reserved indices read as zero R22
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= REG_RESET;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        rdata_o <= rd_data_d;
      end
    end
  end

  // socket-facing controls, all registered
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      disk_interface_mode_o <= '0;
      drive_addr_o <= '0;
      disk_lamp_o <= '0;
      data_drive_en_o <= '1;
      force_8bit_o <= '0;
      pullup_off_o <= '0;
      dma_mode_o <= '0;
      card_transfer_request_o <= '0;
      card_supply_en_o <= '0;
    end else begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        disk_interface_mode_o[s] <= drive_q[s][DRV_DISK_MODE_BIT]; // R2
        if (drive_q[s][DRV_DISK_MODE_BIT]) begin
          drive_addr_o[s] <= drive_q[s][DRV_ADDR_MSB:DRV_ADDR_LSB]; // R6
        end else begin
          drive_addr_o[s] <= '0; // R7
        end
        disk_lamp_o[s] <= speaker_lamp[s]
                          & (io_card_mode_i[s] | drive_q[s][DRV_DISK_MODE_BIT]); // R4
        if (io_map0_hit_i[s]) begin
          data_drive_en_o[s] <= ~mask0_q[s]; // R11 R12
          force_8bit_o[s] <= (mask0_q[s] != MASK_NONE); // R13
        end else if (io_map1_hit_i[s]) begin
          data_drive_en_o[s] <= ~mask1_q[s]; // R14
          force_8bit_o[s] <= (mask1_q[s] != MASK_NONE); // R14
        end else begin
          data_drive_en_o[s] <= '1;
          force_8bit_o[s] <= 1'b0;
        end
        pullup_off_o[s] <= ctrl1_q[s][CTL_PULLUP_OFF_BIT]; // R19
        dma_mode_o[s] <= (ctrl1_q[s][CTL_DMA_MSB:CTL_DMA_LSB] != DMA_OFF); // R20
        case (ctrl1_q[s][CTL_DMA_MSB:CTL_DMA_LSB]) // R20
          DMA_INPACK: card_transfer_request_o[s] <= ~sync2_q[s][PIN_INPACK];
          DMA_WP: card_transfer_request_o[s] <= ~sync2_q[s][PIN_WP];
          DMA_SPKR: card_transfer_request_o[s] <= ~sync2_q[s][PIN_BVD2];
          default: card_transfer_request_o[s] <= 1'b0;
        endcase
        card_supply_en_o[s] <= power_q[s][PWR_SUPPLY_BIT];
      end
    end
  end

  // shared pins: IRQ12 lamp and activity lamp
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq12_o <= 1'b0;
      irq12_oe_n_o <= 1'b1;
      activity_lamp_out_n_o <= 1'b1;
    end else begin
      irq12_o <= 1'b0;
      irq12_oe_n_o <= ~(lamp_drive_enable_i & (|speaker_lamp)); // R3 R17
      activity_lamp_out_n_o <= ~(|activity); // R18
    end
  end

  a_sig_first_read: assert property (@(posedge clock_i) disable iff (!rstn_i) // R1
    (rd_i && !wr_i && index_i == IDX_SIGNATURE && !sig_second_q)
    |=> rdata_o[SIG_ID_MSB:SIG_ID_LSB] == SIG_FIRST ##0 rvalid_o)
    else $error("signature first read wrong");
  a_sig_alternate: assert property (@(posedge clock_i) disable iff (!rstn_i) // R1
    (rd_i && !wr_i && index_i == IDX_SIGNATURE) |=> sig_second_q != $past(sig_second_q))
    else $error("signature did not alternate");
  a_sig_second_read: assert property (@(posedge clock_i) disable iff (!rstn_i) // R1
    (rd_i && !wr_i && index_i == IDX_SIGNATURE && sig_second_q)
    |=> rdata_o[SIG_ID_MSB:SIG_ID_LSB] == SIG_SECOND ##0 rvalid_o)
    else $error("signature second read wrong");
  a_sig_restart: assert property (@(posedge clock_i) disable iff (!rstn_i) // R1
    (wr_i && !rd_i && index_i == IDX_SIGNATURE) |=> !sig_second_q)
    else $error("signature write did not restart");
  a_disk_addr_out: assert property (@(posedge clock_i) disable iff (!rstn_i) // R6 R7
    ##1 drive_addr_o[0] == ($past(drive_q[0][DRV_DISK_MODE_BIT])
      ? $past(drive_q[0][DRV_ADDR_MSB:DRV_ADDR_LSB]) : 5'h00))
    else $error("drive address lines wrong");
  a_disk_mode_out: assert property (@(posedge clock_i) disable iff (!rstn_i) // R2
    ##1 disk_interface_mode_o[0] == $past(drive_q[0][DRV_DISK_MODE_BIT]))
    else $error("disk mode output wrong");
  a_ext_write_read: assert property (@(posedge clock_i) disable iff (!rstn_i) // R8 R10
    (wr_i && !sock_i && index_i == IDX_EXT_DATA && ext_index_q[0] == EXT_MASK0)
    |=> mask0_q[0] == $past(wdata_i))
    else $error("indirect register write lost");
  a_rsvd_zero: assert property (@(posedge clock_i) disable iff (!rstn_i) // R22
    (rd_i && !sock_i && index_i == IDX_EXT_DATA && ext_index_q[0] >= EXT_RSVD_LO
      && ext_index_q[0] <= EXT_RSVD_HI) |=> rdata_o == 8'h00)
    else $error("reserved index read not zero");
  a_mask_drive: assert property (@(posedge clock_i) disable iff (!rstn_i) // R11 R13
    io_map0_hit_i[0] |=> data_drive_en_o[0] == ~$past(mask0_q[0])
      && force_8bit_o[0] == ($past(mask0_q[0]) != 8'h00))
    else $error("map 0 mask not applied");
  a_power_lock: assert property (@(posedge clock_i) disable iff (!rstn_i) // R15
    (wr_i && !sock_i && index_i == IDX_POWER_CTRL && ctrl1_q[0][CTL_POWER_LOCK_BIT]
      && !removal[0]) |=> $stable(power_q[0][PWR_SUPPLY_BIT]))
    else $error("locked supply bit changed");
  a_auto_clear: assert property (@(posedge clock_i) disable iff (!rstn_i) // R16
    (removal[0] && !ctrl1_q[0][CTL_AUTO_CLR_DIS_BIT]) |=> ##1 !card_supply_en_o[0])
    else $error("supply not cleared on removal");
  a_irq12_lamp: assert property (@(posedge clock_i) disable iff (!rstn_i) // R3 R17
    !irq12_oe_n_o |-> $past(lamp_drive_enable_i) && $past(|speaker_lamp) && !irq12_o)
    else $error("IRQ12 driven without cause");
  a_activity_lamp: assert property (@(posedge clock_i) disable iff (!rstn_i) // R18
    (card_cycle_i[0] && ctrl1_q[0][CTL_ACT_LAMP_BIT]) |=> !activity_lamp_out_n_o)
    else $error("activity lamp not lit");
  a_lamp_input: assert property (@(posedge clock_i) disable iff (!rstn_i) // R4
    !drive_q[0][DRV_LAMP_INPUT_BIT] |=> !disk_lamp_o[0])
    else $error("lamp input active while option clear");
  a_dma_off: assert property (@(posedge clock_i) disable iff (!rstn_i) // R20
    (ctrl1_q[0][CTL_DMA_MSB:CTL_DMA_LSB] == DMA_OFF)
    |=> !dma_mode_o[0] && !card_transfer_request_o[0])
    else $error("socket in DMA mode with field clear");
endmodule // socket_extension_regs

// >>> card_model.sv
// card-side model: drives detect and status pins of each socket
`timescale 1ns/1ps
module card_model #(
  parameter int N = 2
) (
  input wire logic [N-1:0] insert_i, // card seated in socket
  input wire logic [N-1:0][2:0] low_i, // pins pulled low: inpack, wp, bvd2
  output logic [N-1:0] present_o, // card detect
  output logic [N-1:0] bvd2_n_o, // battery/speaker/lamp pin
  output logic [N-1:0] inpack_n_o, // input acknowledge pin
  output logic [N-1:0] wp_n_o // write protect pin
);
  // an empty socket floats its status pins up to the pull-up level
  always_comb begin
    for (int s = 0; s < N; s++) begin
      present_o[s] = insert_i[s];
      inpack_n_o[s] = ~(insert_i[s] & low_i[s][0]);
      wp_n_o[s] = ~(insert_i[s] & low_i[s][1]);
      bvd2_n_o[s] = ~(insert_i[s] & low_i[s][2]);
    end
  end
endmodule // card_model

// >>> tb.sv
// self-checking bench for the socket extension register bank
`timescale 1ns/1ps
module tb;
  import sockext_pkg::*;
  localparam logic [1:0] SIG_A = 2'h2; // arbitrary value
  localparam logic [1:0] SIG_B = 2'h1; // arbitrary value
  logic clock_i = 0, rstn_i = 0, sock_i = 0, wr_i = 0, rd_i = 0, lamp_drive_enable_i = 0;
  logic [7:0] index_i = 0, wdata_i = 0, rdata_o, v;
  logic [1:0] io_card_mode_i = 0, card_cycle_i = 0, io_map0_hit_i = 0, io_map1_hit_i = 0;
  logic [1:0] insert = 2'b11, present, bvd2_n, inpack_n, wp_n, disk_mode, disk_lamp;
  logic [1:0] force_8bit, pullup_off, dma_mode, request, supply_en;
  logic [1:0][2:0] low = 0;
  logic [1:0][4:0] drive_addr;
  logic [1:0][7:0] drive_en, dv;
  logic rvalid_o, irq12_o, irq12_oe_n_o, activity_lamp_out_n_o;
  logic [31:0] rnd = 32'h3bea;
  logic [7:0] expq[$];
  int checks = 0, miscompares = 0;
  socket_extension_regs #(.NUM_SOCKETS(2), .SIG_FIRST(SIG_A), .SIG_SECOND(SIG_B),
    .SIG_REVISION(4'h5), .SIG_BIT0(1'b0)) dut_u (.clock_i(clock_i), .rstn_i(rstn_i),
    .sock_i(sock_i), .index_i(index_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .lamp_drive_enable_i(lamp_drive_enable_i),
    .io_card_mode_i(io_card_mode_i), .card_cycle_i(card_cycle_i),
    .io_map0_hit_i(io_map0_hit_i), .io_map1_hit_i(io_map1_hit_i), .card_present_i(present),
    .battery_speaker_lamp_pin_i(bvd2_n), .inpack_n_i(inpack_n), .wp_iois16_n_i(wp_n),
    .disk_interface_mode_o(disk_mode), .drive_addr_o(drive_addr), .disk_lamp_o(disk_lamp),
    .irq12_o(irq12_o), .irq12_oe_n_o(irq12_oe_n_o),
    .activity_lamp_out_n_o(activity_lamp_out_n_o), .data_drive_en_o(drive_en),
    .force_8bit_o(force_8bit), .pullup_off_o(pullup_off), .dma_mode_o(dma_mode),
    .card_transfer_request_o(request), .card_supply_en_o(supply_en));
  card_model #(.N(2)) card_u (.insert_i(insert), .low_i(low), .present_o(present),
    .bvd2_n_o(bvd2_n), .inpack_n_o(inpack_n), .wp_n_o(wp_n));
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  function automatic logic [7:0] nxt();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic s, input logic [7:0] i, input logic [7:0] d);
    @(posedge clock_i);
    sock_i <= s;
    index_i <= i;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge clock_i);
    wr_i <= 0;
  endtask
  task automatic rd(input logic s, input logic [7:0] i, input logic [7:0] e);
    @(posedge clock_i);
    sock_i <= s;
    index_i <= i;
    rd_i <= 1;
    expq.push_back(e);
    @(posedge clock_i);
    rd_i <= 0;
    @(posedge clock_i);
  endtask
  task automatic xw(input logic s, input logic [7:0] x, input logic [7:0] d);
    wr(s, IDX_EXT_INDEX, x);
    wr(s, IDX_EXT_DATA, d);
  endtask
  task automatic xr(input logic s, input logic [7:0] x, input logic [7:0] e);
    wr(s, IDX_EXT_INDEX, x);
    rd(s, IDX_EXT_DATA, e);
  endtask
  task automatic settle();
    repeat (5) @(posedge clock_i);
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // read results are matched in issue order
  always @(negedge clock_i) begin
    if (rvalid_o === 1'b1) begin
      if (expq.size() == 0) begin
        miscompares++;
        $display("ERROR %0t unexpected read data", $time);
      end else chk(rdata_o, expq.pop_front());
    end
  end
  initial begin
    #1000000;
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    repeat (3) @(posedge clock_i);
    rstn_i <= 1;
    rd(0, IDX_SIGNATURE, {SIG_A, 6'h2a});
    rd(1, IDX_SIGNATURE, {SIG_B, 6'h2a});
    rd(0, IDX_SIGNATURE, {SIG_A, 6'h2a});
    wr(1, IDX_SIGNATURE, 8'hff);
    rd(0, IDX_SIGNATURE, {SIG_A, 6'h2a});
    rd(0, IDX_SIGNATURE, {SIG_B, 6'h2a});
    $display("test signature done");
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 2; s++) begin
        v = nxt();
        dv[s] = {v[7:2], 1'b0, m[0]};
        wr(s[0], IDX_DRIVE_CTRL, dv[s]);
      end
      settle();
      for (int s = 0; s < 2; s++) begin
        rd(s[0], IDX_DRIVE_CTRL, dv[s]);
        chk(disk_mode[s], m[0]);
        chk(drive_addr[s], m[0] ? dv[s][7:3] : 5'h0);
      end
    end
    $display("test drive control done");
    for (int s = 0; s < 2; s++) begin
      for (int x = 0; x < 13; x++) begin
        v = nxt();
        xr(s[0], 8'(x), 8'h00);
        xw(s[0], 8'(x), v);
        xr(s[0], 8'(x), ((x >= 5 && x <= 9) || x > 11) ? 8'h00 : v);
      end
    end
    for (int s = 0; s < 2; s++) begin
      xw(s[0], EXT_MASK0, 8'h00);
      xw(s[0], EXT_MASK1, 8'h00);
      xw(s[0], EXT_CTRL1, 8'h00);
    end
    $display("test indirect done");
    xw(0, EXT_MASK0, 8'h7f);
    io_map0_hit_i <= 2'b01;
    settle();
    chk(drive_en[0], 8'h80);
    chk(force_8bit[0], 1'b1);
    io_map0_hit_i <= 2'b00;
    io_map1_hit_i <= 2'b01;
    settle();
    chk(drive_en[0], 8'hff);
    chk(force_8bit[0], 1'b0);
    xw(0, EXT_MASK1, 8'h81);
    settle();
    chk(drive_en[0], 8'h7e);
    chk(force_8bit[0], 1'b1);
    chk(drive_en[1], 8'hff);
    io_map1_hit_i <= 2'b00;
    $display("test masks done");
    for (int s = 0; s < 2; s++) begin
      wr(s[0], IDX_POWER_CTRL, 8'h10);
      settle();
      chk(supply_en[s], 1'b1);
      xw(s[0], EXT_CTRL1, 8'h03);
      wr(s[0], IDX_POWER_CTRL, 8'h00);
      insert[s] <= 0;
      settle();
      chk(supply_en[s], 1'b1);
      insert[s] <= 1;
      xw(s[0], EXT_CTRL1, 8'h01);
      insert[s] <= 0;
      settle();
      chk(supply_en[s], 1'b0);
      insert[s] <= 1;
      wr(s[0], IDX_POWER_CTRL, 8'h10);
      settle();
      chk(supply_en[s], 1'b0);
      xw(s[0], EXT_CTRL1, 8'h00);
    end
    $display("test power done");
    io_card_mode_i <= 2'b01;
    wr(0, IDX_DRIVE_CTRL, 8'h02);
    low[0] <= 3'b100;
    lamp_drive_enable_i <= 1;
    settle();
    chk(irq12_oe_n_o, 1'b0);
    chk(irq12_o, 1'b0);
    chk(disk_lamp[0], 1'b1);
    lamp_drive_enable_i <= 0;
    settle();
    chk(irq12_oe_n_o, 1'b1);
    low[0] <= 3'b000;
    xw(1, EXT_CTRL1, 8'h24);
    card_cycle_i <= 2'b10;
    settle();
    chk(activity_lamp_out_n_o, 1'b0);
    chk(pullup_off[1], 1'b1);
    card_cycle_i <= 2'b00;
    settle();
    chk(activity_lamp_out_n_o, 1'b1);
    $display("test lamps done");
    for (int c = 1; c < 4; c++) begin
      xw(0, EXT_CTRL1, {c[1:0], 6'h0});
      low[0] <= 3'(1 << (c - 1));
      settle();
      chk(dma_mode[0], 1'b1);
      chk(request[0], 1'b1);
      low[0] <= ~3'(1 << (c - 1));
      settle();
      chk(request[0], 1'b0);
    end
    xw(0, EXT_CTRL1, 8'h00);
    settle();
    chk(dma_mode[0], 1'b0);
    $display("test dma done");
    conclude();
  end
endmodule // tb
